// ==== src/lvds_7to1_deserializer.sv ====
`timescale 1ns/1ns
`include "lvds_rx_params.svh"
module lvds_7to1_deserializer #(
    parameter int LANES = `LANES_WIDE,
    parameter int LOCK_CYCLES = `LOCK_CYCLES,
    parameter int CLK_LOSS_CYCLES = `CLK_LOSS_CYCLES
) (
    // Master clock and reset
    input wire logic i_mclk,
    input wire logic i_nrst,
    // Link side: bit-rate strobe clock, forwarded clock lane, data lanes
    input wire logic i_link_clock_in,
    input wire logic i_clock_lane,
    input wire logic [LANES-1:0] i_serial_lane_in,
    // Control pin
    input wire logic i_power_down_n,
    // Parallel side
    output logic [LANES*`BITS_PER_LANE-1:0] o_parallel_word_out,
    output logic o_recovered_clock_out,
    output lvds_rx_pkg::out_state_e o_state,
    // Status
    output logic o_link_locked,
    output logic o_lock_late
);
    import lvds_rx_pkg::*;

    localparam int W = LANES * `BITS_PER_LANE;
    localparam int LOSS_W = $clog2(CLK_LOSS_CYCLES + 1);
    localparam int LOCK_W = $clog2(LOCK_CYCLES + 1);

    // Only the wide and narrow builds exist
    generate
        if (LANES != `LANES_WIDE && LANES != `LANES_NARROW) begin : g_bad_lanes
            $error("LANES must be 3 or 4");
        end
        if (CLK_LOSS_CYCLES < 8 || LOCK_CYCLES < 1) begin : g_bad_counts
            $error("timeout counts too small");
        end
        if (`PD_ENTRY_CYCLES < 6) begin : g_bad_pd
            $error("power-down path too slow for entry time");
        end
    endgenerate

    // ---------------- Link clock domain ----------------

    logic lrst_meta_reg;
    logic lrst_n_reg;
    // Reset release synchronised; assertion stays asynchronous
    always_ff @(posedge i_link_clock_in or negedge i_nrst) begin
        if (!i_nrst) begin
            lrst_meta_reg <= 1'b0;
            lrst_n_reg <= 1'b0;
        end else begin
            lrst_meta_reg <= 1'b1;
            lrst_n_reg <= lrst_meta_reg;
        end
    end

    logic lpd1_reg;
    logic lpd2_reg;
    logic lpd3_reg;
    logic lpd_n_reg;
    // Power-down pin into link domain, counted once two stages agree
    always_ff @(posedge i_link_clock_in or negedge lrst_n_reg) begin
        if (!lrst_n_reg) begin
            lpd1_reg <= 1'b0;
            lpd2_reg <= 1'b0;
            lpd3_reg <= 1'b0;
            lpd_n_reg <= 1'b0;
        end else begin
            lpd1_reg <= i_power_down_n;
            lpd2_reg <= lpd1_reg;
            lpd3_reg <= lpd2_reg;
            if (lpd2_reg == lpd3_reg) begin
                lpd_n_reg <= lpd3_reg;
            end
        end
    end

    bit_index_t bit_cnt_reg;
    logic [`BITS_PER_LANE-1:0] clk_sr_reg;
    logic [`BITS_PER_LANE-1:0] lane_sr_reg [LANES];
    logic frame_end;
    logic frame_ok;

    assign frame_end = (bit_cnt_reg == bit_index_t'(`BITS_PER_LANE - 1));
    assign frame_ok = (clk_sr_reg == `CLK_LANE_PATTERN);

    // Bit position within the period; a bad clock-lane shape slips one bit
    always_ff @(posedge i_link_clock_in or negedge lrst_n_reg) begin
        if (!lrst_n_reg) begin
            bit_cnt_reg <= 3'h0;
        end else if (!lpd_n_reg) begin
            bit_cnt_reg <= 3'h0;
        end else if (frame_end) begin
            bit_cnt_reg <= frame_ok ? 3'h0 : 3'h1;
        end else begin
            bit_cnt_reg <= bit_cnt_reg + 3'h1;
        end
    end

    // Clock lane shape is shifted like data so its boundary marks bit 0
    always_ff @(posedge i_link_clock_in or negedge lrst_n_reg) begin
        if (!lrst_n_reg) begin
            clk_sr_reg <= 7'h00;
        end else begin
            clk_sr_reg <= {clk_sr_reg[`BITS_PER_LANE-2:0], i_clock_lane};
        end
    end

    logic [W-1:0] frame_word;
    genvar gl;
    genvar gk;
    // One strobe per bit clock; bit 0 ends at the top of each shifter
    generate
        for (gl = 0; gl < LANES; gl++) begin : g_lane
            always_ff @(posedge i_link_clock_in or negedge lrst_n_reg) begin
                if (!lrst_n_reg) begin
                    lane_sr_reg[gl] <= 7'h00;
                end else begin
                    lane_sr_reg[gl] <= {lane_sr_reg[gl][`BITS_PER_LANE-2:0],
                                        i_serial_lane_in[gl]};
                end
            end
            for (gk = 0; gk < `BITS_PER_LANE; gk++) begin : g_bit
                // Fixed placement shared with the transmitter
                assign frame_word[gl*`BITS_PER_LANE+gk] =
                    lane_sr_reg[gl][`BITS_PER_LANE-1-gk];
            end
        end
    endgenerate

    logic [2:0] good_cnt_reg;
    logic llock_reg;
    // Lock after several clean clock-lane frames in a row
    always_ff @(posedge i_link_clock_in or negedge lrst_n_reg) begin
        if (!lrst_n_reg) begin
            good_cnt_reg <= 3'h0;
            llock_reg <= 1'b0;
        end else if (!lpd_n_reg) begin
            good_cnt_reg <= 3'h0;
            llock_reg <= 1'b0;
        end else if (frame_end) begin
            if (!frame_ok) begin
                good_cnt_reg <= 3'h0;
                llock_reg <= 1'b0;
            end else if (good_cnt_reg != 3'(`LOCK_FRAMES)) begin
                good_cnt_reg <= good_cnt_reg + 3'h1;
            end else begin
                llock_reg <= 1'b1;
            end
        end
    end

    logic [W-1:0] word_a_reg;
    logic [W-1:0] word_b_reg;
    logic word_tgl_reg;
    // Two-word pipeline gives the fixed latency; the toggle announces
    // word_b, which then stands a whole link period for the crossing
    always_ff @(posedge i_link_clock_in or negedge lrst_n_reg) begin
        if (!lrst_n_reg) begin
            word_a_reg <= '0;
            word_b_reg <= '0;
            word_tgl_reg <= 1'b0;
        end else if (frame_end && frame_ok && lpd_n_reg) begin
            word_a_reg <= frame_word;
            word_b_reg <= word_a_reg;
            word_tgl_reg <= ~word_tgl_reg;
        end
    end

    // ---------------- Master clock domain ----------------

    logic t1_reg;
    logic t2_reg;
    logic t3_reg;
    logic seen_reg;
    logic k1_reg;
    logic k2_reg;
    logic k3_reg;
    logic lock_reg;
    logic p1_reg;
    logic p2_reg;
    logic p3_reg;
    logic pd_n_reg;
    logic word_evt;

    // Three-stage synchronisers; a change counts once stages two and three agree
    always_ff @(posedge i_mclk or negedge i_nrst) begin
        if (!i_nrst) begin
            t1_reg <= 1'b0;
            t2_reg <= 1'b0;
            t3_reg <= 1'b0;
            k1_reg <= 1'b0;
            k2_reg <= 1'b0;
            k3_reg <= 1'b0;
            p1_reg <= 1'b0;
            p2_reg <= 1'b0;
            p3_reg <= 1'b0;
        end else begin
            t1_reg <= word_tgl_reg;
            t2_reg <= t1_reg;
            t3_reg <= t2_reg;
            k1_reg <= llock_reg;
            k2_reg <= k1_reg;
            k3_reg <= k2_reg;
            p1_reg <= i_power_down_n;
            p2_reg <= p1_reg;
            p3_reg <= p2_reg;
        end
    end

    // Filtered levels
    always_ff @(posedge i_mclk or negedge i_nrst) begin
        if (!i_nrst) begin
            seen_reg <= 1'b0;
            lock_reg <= 1'b0;
            pd_n_reg <= 1'b0;
        end else begin
            if (t2_reg == t3_reg) begin
                seen_reg <= t3_reg;
            end
            if (k2_reg == k3_reg) begin
                lock_reg <= k3_reg;
            end
            if (p2_reg == p3_reg) begin
                pd_n_reg <= p3_reg;
            end
        end
    end

    assign word_evt = (t2_reg == t3_reg) && (t3_reg != seen_reg);

    out_state_e state_reg;
    out_state_e state_next;
    logic [LOSS_W-1:0] idle_cnt_reg;

    // Output mode: powered down, running, or clock lost
    always_comb begin
        state_next = state_reg;
        unique case (state_reg)
            ST_POWER_DOWN: begin
                if (pd_n_reg) begin
                    state_next = ST_RUN;
                end
            end
            ST_RUN: begin
                if (idle_cnt_reg == LOSS_W'(CLK_LOSS_CYCLES)) begin
                    state_next = ST_CLOCK_LOST;
                end
            end
            ST_CLOCK_LOST: begin
                if (word_evt) begin
                    state_next = ST_RUN;
                end
            end
            default: state_next = ST_POWER_DOWN;
        endcase
        if (!pd_n_reg) begin
            state_next = ST_POWER_DOWN;
        end
    end

    always_ff @(posedge i_mclk or negedge i_nrst) begin
        if (!i_nrst) begin
            state_reg <= ST_POWER_DOWN;
        end else begin
            state_reg <= state_next;
        end
    end

    // Cycles since the last word; saturates
    always_ff @(posedge i_mclk or negedge i_nrst) begin
        if (!i_nrst) begin
            idle_cnt_reg <= '0;
        end else if (word_evt || state_reg != ST_RUN) begin
            idle_cnt_reg <= '0;
        end else if (idle_cnt_reg != LOSS_W'(CLK_LOSS_CYCLES)) begin
            idle_cnt_reg <= idle_cnt_reg + LOSS_W'(1);
        end
    end

    logic [1:0] hi_cnt_reg;
    // Data moves first, clock rises one cycle later, so the rising edge
    // lands in mid-word; idle all-high lanes simply arrive as all ones
    always_ff @(posedge i_mclk or negedge i_nrst) begin
        if (!i_nrst) begin
            o_parallel_word_out <= '0;
        end else if (state_next == ST_POWER_DOWN) begin
            o_parallel_word_out <= '0;
        end else if (word_evt) begin
            o_parallel_word_out <= word_b_reg;
        end
    end

    // One output strobe per word received while the state stays ST_RUN keeps the periods equal
    always_ff @(posedge i_mclk or negedge i_nrst) begin
        if (!i_nrst) begin
            o_recovered_clock_out <= 1'b0;
            hi_cnt_reg <= 2'h0;
        end else if (state_reg != ST_RUN || state_next != ST_RUN) begin
            o_recovered_clock_out <= 1'b0;
            hi_cnt_reg <= 2'h0;
        end else if (word_evt) begin
            o_recovered_clock_out <= 1'b0;
            hi_cnt_reg <= 2'(`STROBE_HIGH_CYCLES) + 2'h1;
        end else if (hi_cnt_reg != 2'h0) begin
            o_recovered_clock_out <= (hi_cnt_reg != 2'h1) || 1'b0;
            hi_cnt_reg <= hi_cnt_reg - 2'h1;
        end else begin
            o_recovered_clock_out <= 1'b0;
        end
    end

    logic [LOCK_W-1:0] lock_wait_reg;
    // Watchdog flags a link that fails to lock in time
    always_ff @(posedge i_mclk or negedge i_nrst) begin
        if (!i_nrst) begin
            lock_wait_reg <= '0;
            o_lock_late <= 1'b0;
            o_link_locked <= 1'b0;
            o_state <= ST_POWER_DOWN;
        end else begin
            o_link_locked <= lock_reg && pd_n_reg;
            o_state <= state_next;
            if (lock_reg || !pd_n_reg) begin
                lock_wait_reg <= '0;
                o_lock_late <= 1'b0;
            end else if (lock_wait_reg == LOCK_W'(LOCK_CYCLES)) begin
                o_lock_late <= 1'b1;
            end else begin
                lock_wait_reg <= lock_wait_reg + LOCK_W'(1);
            end
        end
    end

endmodule

// ==== src/lvds_rx_params.svh ====
`ifndef LVDS_RX_PARAMS_SVH
`define LVDS_RX_PARAMS_SVH

// Word framing
`define BITS_PER_LANE 7
`define LANES_WIDE 4
`define LANES_NARROW 3
`define CLK_LANE_PATTERN 7'h63
`define LOCK_FRAMES 4
`define LATENCY_WORDS 2

// Timing, master clock 25 MHz
`define MCLK_NS 40
`define PERIOD_MIN_NS 15
`define PERIOD_MAX_NS 50
`define LOCK_TIME_NS 10000000
`define LOCK_CYCLES (`LOCK_TIME_NS / `MCLK_NS)
`define PD_ENTRY_NS 1000
`define PD_ENTRY_CYCLES (`PD_ENTRY_NS / `MCLK_NS)
`define CLK_LOSS_CYCLES 16
`define STROBE_HIGH_CYCLES 2
`endif

// ==== src/lvds_rx_pkg.sv ====
package lvds_rx_pkg;
    // Output side state
    typedef enum logic [1:0] {
        ST_POWER_DOWN = 2'b00,
        ST_RUN = 2'b01,
        ST_CLOCK_LOST = 2'b10
    } out_state_e;
    typedef logic [2:0] bit_index_t;
endpackage

// ==== tb/lvds_7to1_deserializer_tb.sv ====
`timescale 1ns/1ns
module lvds_7to1_deserializer_tb;
    import lvds_rx_pkg::*;
    localparam int W = 28;
    logic i_mclk = 1'b0;
    logic i_nrst = 1'b0;
    logic pd_n = 1'b1, run = 1'b1, idle = 1'b0;
    logic lclk, clane, tick, rclk, locked, late;
    logic [3:0] lanes;
    logic [W-1:0] wd = '0;
    logic [W-1:0] last, pw;
    logic [W-1:0] exp_q[$];
    logic [31:0] lfsr = 32'h6b40_56cf;
    out_state_e state;
    int err_total = 0;
    int checked = 0;
    bit synced = 1'b0;
    int tick_n = 0;
    int lat;
    int tq[$];
    // Master clock
    initial forever #20 i_mclk = ~i_mclk;
    lvds_link_tx_model u_lvds_link_tx_model (.i_run(run), .i_idle(idle), .i_word(wd),
        .o_link_clock(lclk), .o_clock_lane(clane), .o_lanes(lanes), .o_tick(tick));
    // Lock window cut to 200 mclk to keep the run short
    lvds_7to1_deserializer #(.LANES(4), .LOCK_CYCLES(200), .CLK_LOSS_CYCLES(16))
        u_lvds_7to1_deserializer (.i_mclk(i_mclk), .i_nrst(i_nrst), .i_link_clock_in(lclk),
        .i_clock_lane(clane), .i_serial_lane_in(lanes), .i_power_down_n(pd_n),
        .o_parallel_word_out(pw), .o_recovered_clock_out(rclk), .o_state(state),
        .o_link_locked(locked), .o_lock_late(late));
    function automatic logic [31:0] lfsr_step(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    task automatic check(input string what, input logic [W-1:0] exp, input logic [W-1:0] got);
        checked++;
        if (got !== exp) begin
            err_total++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic summarize();
        $display("checked %0d err_total %0d", checked, err_total);
        if (err_total == 0 && checked > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    // One note per word handed to the serializer, in order
    task automatic send(input int n, input logic hi);
        repeat (n) begin
            @(tick);
            @(posedge i_mclk);
            lfsr = lfsr_step(lfsr);
            wd <= lfsr[W-1:0];
            idle <= hi;
            last = hi ? '1 : lfsr[W-1:0];
            exp_q.push_back(last);
            tq.push_back(tick_n);
        end
    endtask
    task automatic phase(input int n);
        int t;
        t = 0;
        synced = 1'b0;
        exp_q.delete();
        tq.delete();
        // A restarted link may slip and drop framing; a stale lock must not pass
        repeat (100) @(posedge i_mclk);
        while (locked !== 1'b1 && t < 200) begin
            @(posedge i_mclk);
            t++;
        end
        check("locked", W'(1), W'(locked));
        check("lock_late", '0, W'(late));
        repeat (40) @(posedge i_mclk);
        send(n, 1'b0);
        send(6, 1'b1);
        send(4, 1'b0);
        repeat (60) @(posedge i_mclk);
        check("synced", W'(1), W'(synced));
        check("drained", '0, W'(exp_q.size()));
        $display("phase of %0d words done", n);
    endtask
    // Frame hand-overs seen by the serializer
    always @(tick) begin
        tick_n = tick_n + 1;
    end
    // Scoreboard: waits for the oldest note to show, then one note per strobe
    // A note leads its shifting by one period, then two pipeline periods and the
    // crossing follow, so the word shows three or four hand-overs after its note
    always @(posedge rclk) begin
        if (state === ST_RUN && exp_q.size() > 0 && (synced || exp_q[0] === pw)) begin
            synced = 1'b1;
            lat = tick_n - tq.pop_front();
            check("latency", W'(1), W'(lat == 3 || lat == 4));
            check("word", exp_q.pop_front(), pw);
        end
    end
    initial begin
        repeat (2) @(posedge i_mclk);
        i_nrst <= 1'b1;
        check("width", W'(28), W'($bits(u_lvds_7to1_deserializer.o_parallel_word_out)));
        phase(40);
        run <= 1'b0;
        repeat (40) @(posedge i_mclk);
        check("lost_state", W'(ST_CLOCK_LOST), W'(state));
        check("lost_word", last, pw);
        check("lost_strobe", '0, W'(rclk));
        $display("clock loss done");
        run <= 1'b1;
        phase(12);
        pd_n <= 1'b0;
        repeat (25) @(posedge i_mclk);
        check("pd_word", '0, pw);
        check("pd_state", W'(ST_POWER_DOWN), W'(state));
        $display("power down done");
        pd_n <= 1'b1;
        phase(12);
        summarize();
    end
    // Three lock waits plus about 90 frames need well under this span
    initial begin
        #200_000;
        err_total++;
        summarize();
    end
endmodule

// ==== tb/lvds_deser_sva.sv ====
`timescale 1ns/1ns
`include "lvds_rx_params.svh"
module lvds_deser_sva
    import lvds_rx_pkg::*;
#(
    parameter int LANES = 4
) (
    // Watched pins
    input wire logic i_mclk,
    input wire logic i_nrst,
    input wire logic i_power_down_n,
    input wire logic [LANES*`BITS_PER_LANE-1:0] o_parallel_word_out,
    input wire logic o_recovered_clock_out,
    input wire logic [1:0] o_state
);
    // 1 us entry bound in master clock cycles
    localparam int PD_MAX = `PD_ENTRY_CYCLES;
    default clocking cb @(posedge i_mclk); endclocking
    default disable iff (!i_nrst);
    // Strobe shape: two cycles high, then at least three low
    sequence s_hi;
        o_recovered_clock_out ##1 !o_recovered_clock_out;
    endsequence
    sequence s_lo;
        !o_recovered_clock_out [*2];
    endsequence
    // Power-down cuts the strobe short, so edge checks stand aside then
    property p_shape;
        disable iff (!i_nrst || !i_power_down_n)
        $rose(o_recovered_clock_out) |=> s_hi ##1 s_lo;
    endproperty
    property p_edge;
        disable iff (!i_nrst || !i_power_down_n)
        $rose(o_recovered_clock_out) |-> $stable(o_parallel_word_out) ##1
            $stable(o_parallel_word_out);
    endproperty
    property p_change;
        $changed(o_parallel_word_out) && o_state == ST_RUN |-> !o_recovered_clock_out;
    endproperty
    property p_pd_zero;
        (!i_power_down_n) [*8] |-> o_parallel_word_out == '0;
    endproperty
    property p_pd_mode;
        o_state == ST_POWER_DOWN |-> o_parallel_word_out == '0 && !o_recovered_clock_out;
    endproperty
    property p_pd_entry;
        $fell(i_power_down_n) |-> ##[1:PD_MAX] o_state == ST_POWER_DOWN;
    endproperty
    property p_pd_stay;
        !i_power_down_n && o_state == ST_POWER_DOWN |=> o_state == ST_POWER_DOWN;
    endproperty
    property p_lost;
        o_state == ST_CLOCK_LOST |-> !o_recovered_clock_out && $stable(o_parallel_word_out);
    endproperty
    a_shape: assert property (p_shape) else $error("strobe shape");
    a_edge: assert property (p_edge) else $error("word moved at strobe");
    a_change: assert property (p_change) else $error("word moved while high");
    a_pd_zero: assert property (p_pd_zero) else $error("word not low");
    a_pd_mode: assert property (p_pd_mode) else $error("pins not low");
    a_pd_entry: assert property (p_pd_entry) else $error("entry late");
    a_pd_stay: assert property (p_pd_stay) else $error("left power-down");
    a_lost: assert property (p_lost) else $error("lost state not held");
endmodule
bind lvds_7to1_deserializer lvds_deser_sva #(.LANES(LANES)) u_lvds_deser_sva (
    .i_mclk(i_mclk), .i_nrst(i_nrst), .i_power_down_n(i_power_down_n),
    .o_parallel_word_out(o_parallel_word_out),
    .o_recovered_clock_out(o_recovered_clock_out), .o_state(o_state));

// ==== tb/lvds_link_tx_model.sv ====
`timescale 1ns/1ns
module lvds_link_tx_model (
    // Bench control
    input wire logic i_run,
    input wire logic i_idle,
    input wire logic [27:0] i_word,
    // Link pins and word-taken toggle
    output logic o_link_clock,
    output logic o_clock_lane,
    output logic [3:0] o_lanes,
    output logic o_tick
);
    localparam logic [6:0] CLK_PAT = 7'h63;
    logic [27:0] sh_reg;
    logic [2:0] k_reg;
    // Bit clock stands low while stopped; odd offset keeps it off the mclk edges
    initial begin
        {o_link_clock, o_clock_lane, o_lanes, o_tick, k_reg, sh_reg} = '0;
        #7;
        forever #16 o_link_clock = i_run ? ~o_link_clock : 1'b0;
    end
    // Bit 0 first; lane L bit K carries word bit 7L+K; idle lanes sit high
    always @(posedge o_link_clock) begin
        k_reg <= (k_reg == 3'd6) ? 3'd0 : k_reg + 3'd1;
        o_clock_lane <= CLK_PAT[k_reg];
        if (k_reg == 3'd0) begin
            sh_reg <= i_idle ? '1 : i_word;
            o_tick <= ~o_tick;
        end
        for (int l = 0; l < 4; l++) begin
            o_lanes[l] <= (k_reg == 3'd0) ? (i_idle | i_word[7*l]) : sh_reg[7*l+k_reg];
        end
    end
    // Failsafe bias pulls the pins high once the clock stops
    always @(negedge i_run) begin
        {o_clock_lane, o_lanes} <= '1;
    end
endmodule
